// file: hw/mdas_defs.svh
// constants for the data addressing and special function register block
`ifndef MDAS_DEFS_SVH
`define MDAS_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define MDAS_RAM_WORDS 256
`define MDAS_SFR_WORDS 128
`define MDAS_BIT_BASE 8'h20
`define MDAS_UNDEF_DATA 8'h00

// ----------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------
`define MDAS_PORT0_LATCH 8'h80
`define MDAS_STACK_POINTER 8'h81
`define MDAS_DATA_PTR0_LOW 8'h82
`define MDAS_DATA_PTR0_HIGH 8'h83
`define MDAS_DATA_PTR1_LOW 8'h84
`define MDAS_DATA_PTR1_HIGH 8'h85
`define MDAS_WATCHDOG_RELOAD 8'h86
`define MDAS_UART_SPEED_CTL 8'h87
`define MDAS_TIMER_RUN_CTL 8'h88
`define MDAS_TIMER_MODE_CTL 8'h89
`define MDAS_TIMER0_LOW 8'h8a
`define MDAS_TIMER1_LOW 8'h8b
`define MDAS_TIMER0_HIGH 8'h8c
`define MDAS_TIMER1_HIGH 8'h8d
`define MDAS_MOVX_STRETCH_CTL 8'h8e
`define MDAS_PORT1_LATCH 8'h90
`define MDAS_PORT1_DIRECTION 8'h91
`define MDAS_POINTER_SELECT 8'h92
`define MDAS_FLASH_ERASE_CMD 8'h94
`define MDAS_SERIAL0_CTL 8'h98
`define MDAS_SERIAL0_BUFFER 8'h99
`define MDAS_INT_ENABLE_TWO 8'h9a
`define MDAS_SERIAL1_CTL 8'h9b
`define MDAS_SERIAL1_BUFFER 8'h9c
`define MDAS_SERIAL1_RELOAD_LOW 8'h9d
`define MDAS_SERIAL_EEPROM_BYTE 8'h9e
`define MDAS_SERIAL_EEPROM_CTL 8'h9f
`define MDAS_PORT2_LATCH 8'ha0
`define MDAS_PORT2_DIRECTION 8'ha1
`define MDAS_PORT0_DIRECTION 8'ha2
`define MDAS_INT_ENABLE_ZERO 8'ha8
`define MDAS_INT_PRIORITY_ZERO 8'ha9
`define MDAS_SERIAL0_RELOAD_LOW 8'haa
`define MDAS_PORT3_LATCH 8'hb0
`define MDAS_FLASH_CTL 8'hb2
`define MDAS_FLASH_PAGE_ADDR 8'hb7
`define MDAS_INT_ENABLE_ONE 8'hb8
`define MDAS_INT_PRIORITY_ONE 8'hb9
`define MDAS_SERIAL0_RELOAD_HIGH 8'hba
`define MDAS_SERIAL1_RELOAD_HIGH 8'hbb
`define MDAS_MOVX_PAGE_HIGH 8'hbf
`define MDAS_INT_REQUEST_CTL 8'hc0
`define MDAS_PROG_STATUS_WORD 8'hd0
`define MDAS_BAUD_SELECT_CTL 8'hd8
`define MDAS_ACCUMULATOR 8'he0
`define MDAS_WATCHDOG_KICK_CTL 8'he8
`define MDAS_MUL_DIV_SCRATCH 8'hf0
`define MDAS_INT_FLAG_BITS 8'hf8

// ----------------------------------------------------------------
// reset values: zero first, then those that are not zero
// ----------------------------------------------------------------
`define MDAS_RST_ZERO 8'h00
`define MDAS_RST_PORT 8'hff
`define MDAS_RST_STACK 8'h07
`define MDAS_RST_STRETCH 8'h01
`define MDAS_RST_S0_RELOAD_LOW 8'hd9
`define MDAS_RST_RELOAD_HIGH 8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MDAS_DPS_BIT 0
`define MDAS_BANK_HI 4
`define MDAS_BANK_LO 3
`define MDAS_STRETCH_HI 2
`define MDAS_BIT_ALIGN_MASK 8'hf8
`define MDAS_UPPER_BIT 7
`define MDAS_BITBYTE_HI 6
`define MDAS_BITBYTE_LO 3
`define MDAS_BITPOS_HI 2
`define MDAS_UNDEF_BIT 1'b0
`define MDAS_WR_STROBE_MIN 4'h1
`define MDAS_WR_ADDR_EXTRA 4'h1

`endif

// file: hw/mdas_pkg.sv
// types shared by the data addressing block
`include "mdas_defs.svh"

package mdas_pkg;

   // external data access sequencer
   typedef enum logic [1:0] {
      xs_idle,
      xs_read,
      xs_write
   } mdas_xst_e;

   // whole state of the block
   typedef struct packed {
      logic [`MDAS_RAM_WORDS-1:0][7:0] ram;
      logic [`MDAS_SFR_WORDS-1:0][7:0] special_function_register;
      mdas_xst_e xst;
      logic [3:0] cnt;
      logic [2:0] strch;
      logic [15:0] mem_addr;
      logic mem_addr_vld;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
      logic busy;
      logic done;
      logic [7:0] movx_rdata;
      logic [7:0] rd_data;
      logic rd_bit;
      logic rd_valid;
   } mdas_state_s;

endpackage

// file: hw/mdas_top.sv
// internal data space, special function registers and external data access sequencer
//
// Operation
// R1: paged address low byte from bank reg zero/one
// R2: paged address high byte from page-high register
// R3: pointer access drives address from active pointer
// R4: pointer-select bit zero chooses primary or secondary
// R5: pointer load and increment act on selected
// R6: internal space is 256 bytes, byte addressed
// R7: upper half: direct to registers, indirect RAM
// R8: lowest 32 bytes are four status-selected banks
// R9: bytes 0x20-0x2f also reachable as bits
// R10: lower half reachable directly and indirectly
// R11: unimplemented registers: undefined read, write ignored
// R12: registers at multiples of eight are bit-addressable
// R13: registers take tabulated values at reset
// R14: paged and pointer accesses mix freely
// R15: low three stretch bits give stretch value
// R16: strobe and address widths follow stretch value
// R17: stretch value is one after reset
// R18: pointer select leaves both pointers intact
`timescale 1ns/10ps

// addresses, reset values and timing counts
`include "mdas_defs.svh"

module mdas_top
   import mdas_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // direct byte access
   input wire logic dir_rd,
   input wire logic dir_wr,
   input wire logic [7:0] dir_addr,
   input wire logic [7:0] dir_wdata,
   // indirect byte access
   input wire logic ind_rd,
   input wire logic ind_wr,
   input wire logic [7:0] ind_addr,
   input wire logic [7:0] ind_wdata,
   // bit access
   input wire logic bit_rd,
   input wire logic bit_wr,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wval,
   // read answer for byte and bit access
   output logic rd_valid_q,
   output logic [7:0] rd_data_q,
   output logic rd_bit_q,
   // data pointer operations
   input wire logic primary_data_ptr_load,
   input wire logic [15:0] primary_data_ptr_load_val,
   input wire logic primary_data_ptr_inc,
   // external data access request
   input wire logic movx_req,
   input wire logic movx_wr,
   input wire logic movx_paged,
   input wire logic movx_ri_sel,
   input wire logic [7:0] movx_wdata,
   output logic movx_busy_q,
   output logic movx_done_q,
   output logic [7:0] movx_rdata_q,
   // external data memory interface
   output logic [15:0] mem_addr_q,
   output logic mem_addr_vld_q,
   output logic mem_rd_q,
   output logic mem_wr_q,
   output logic [7:0] mem_wdata_q,
   input wire logic [7:0] mem_rdata
);

   // ----------------------------------------------------------------
   // decoding functions
   // ----------------------------------------------------------------

   // register file slot of an upper-half address
   function automatic logic [6:0] sfr_idx(input logic [7:0] a);
      sfr_idx = a[`MDAS_UPPER_BIT-1:0];
   endfunction

   // top bit splits lower RAM from the register half; all decodes
   // share this so byte, bit and hole paths cannot drift apart
   function automatic logic upper_half(input logic [7:0] a);
      upper_half = a[`MDAS_UPPER_BIT];
   endfunction

   // addresses that hold a register; all others are holes
   function automatic logic sfr_impl(input logic [7:0] a);
      case (a)
         `MDAS_PORT0_LATCH, `MDAS_STACK_POINTER, `MDAS_DATA_PTR0_LOW,
         `MDAS_DATA_PTR0_HIGH, `MDAS_DATA_PTR1_LOW, `MDAS_DATA_PTR1_HIGH,
         `MDAS_WATCHDOG_RELOAD, `MDAS_UART_SPEED_CTL, `MDAS_TIMER_RUN_CTL,
         `MDAS_TIMER_MODE_CTL, `MDAS_TIMER0_LOW, `MDAS_TIMER1_LOW,
         `MDAS_TIMER0_HIGH, `MDAS_TIMER1_HIGH, `MDAS_MOVX_STRETCH_CTL,
         `MDAS_PORT1_LATCH, `MDAS_PORT1_DIRECTION, `MDAS_POINTER_SELECT,
         `MDAS_FLASH_ERASE_CMD, `MDAS_SERIAL0_CTL, `MDAS_SERIAL0_BUFFER,
         `MDAS_INT_ENABLE_TWO, `MDAS_SERIAL1_CTL, `MDAS_SERIAL1_BUFFER,
         `MDAS_SERIAL1_RELOAD_LOW, `MDAS_SERIAL_EEPROM_BYTE,
         `MDAS_SERIAL_EEPROM_CTL, `MDAS_PORT2_LATCH, `MDAS_PORT2_DIRECTION,
         `MDAS_PORT0_DIRECTION, `MDAS_INT_ENABLE_ZERO, `MDAS_INT_PRIORITY_ZERO,
         `MDAS_SERIAL0_RELOAD_LOW, `MDAS_PORT3_LATCH, `MDAS_FLASH_CTL,
         `MDAS_FLASH_PAGE_ADDR, `MDAS_INT_ENABLE_ONE, `MDAS_INT_PRIORITY_ONE,
         `MDAS_SERIAL0_RELOAD_HIGH, `MDAS_SERIAL1_RELOAD_HIGH,
         `MDAS_MOVX_PAGE_HIGH, `MDAS_INT_REQUEST_CTL, `MDAS_PROG_STATUS_WORD,
         `MDAS_BAUD_SELECT_CTL, `MDAS_ACCUMULATOR, `MDAS_WATCHDOG_KICK_CTL,
         `MDAS_MUL_DIV_SCRATCH, `MDAS_INT_FLAG_BITS: begin
            sfr_impl = 1'b1;
         end
         // holes read as a fixed byte and ignore writes
         default: begin
            sfr_impl = 1'b0;
         end
      endcase
   endfunction

   // value a register takes at reset
   // registers with no listed value start at zero
   function automatic logic [7:0] sfr_rst(input logic [7:0] a);
      case (a)
         `MDAS_PORT0_LATCH, `MDAS_PORT1_LATCH, `MDAS_PORT3_LATCH: begin
            sfr_rst = `MDAS_RST_PORT;
         end
         `MDAS_STACK_POINTER: begin
            sfr_rst = `MDAS_RST_STACK;
         end
         `MDAS_MOVX_STRETCH_CTL: begin
            sfr_rst = `MDAS_RST_STRETCH; // R17
         end
         `MDAS_SERIAL0_RELOAD_LOW: begin
            sfr_rst = `MDAS_RST_S0_RELOAD_LOW;
         end
         `MDAS_SERIAL0_RELOAD_HIGH, `MDAS_SERIAL1_RELOAD_HIGH: begin
            sfr_rst = `MDAS_RST_RELOAD_HIGH;
         end
         default: begin
            sfr_rst = `MDAS_RST_ZERO;
         end
      endcase
   endfunction

   // byte that holds a bit address
   function automatic logic [7:0] bit_byte(input logic [7:0] ba);
      // lower bit space: sixteen bytes of eight bits each
      if (!upper_half(ba)) begin
         bit_byte = `MDAS_BIT_BASE | {4'h0, ba[`MDAS_BITBYTE_HI:`MDAS_BITBYTE_LO]}; // R9
      end else begin
         bit_byte = ba & `MDAS_BIT_ALIGN_MASK; // R12
      end
   endfunction

   // register slot of one byte of the chosen pointer
   function automatic logic [6:0] ptr_slot(input logic sel, input logic hi);
      if (sel) begin
         ptr_slot = sfr_idx(hi ? `MDAS_DATA_PTR1_HIGH : `MDAS_DATA_PTR1_LOW);
      end else begin
         ptr_slot = sfr_idx(hi ? `MDAS_DATA_PTR0_HIGH : `MDAS_DATA_PTR0_LOW);
      end
   endfunction

   // whole state after reset
   function automatic mdas_state_s reset_state();
      mdas_state_s r;
      // RAM and holes come up at zero
      r = '0;
      for (int i = 0; i < `MDAS_SFR_WORDS; i++) begin
         r.special_function_register[i] = sfr_rst({1'b1, 7'(i)}); // R13
      end
      r.xst = xs_idle;
      return r;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   mdas_state_s st_q;
   mdas_state_s st_d;

   // pointer decode
   logic dp_sel;
   logic [6:0] dp_lo;
   logic [6:0] dp_hi;
   logic [15:0] dp_val;
   logic [15:0] dp_inc_val;
   // paged address decode
   logic [1:0] bank;
   logic [7:0] ri_addr;
   logic [15:0] pg_addr;
   // bit access decode
   logic [7:0] bb;
   logic [2:0] bpos;
   // sequencer counts
   logic [3:0] cnt_nx;
   logic [3:0] wlen;
   logic [3:0] wr_last;

   // ----------------------------------------------------------------
   // address helpers
   // ----------------------------------------------------------------

   // active pointer; the other pair keeps its bytes untouched
   assign dp_sel = st_q.special_function_register[sfr_idx(`MDAS_POINTER_SELECT)][`MDAS_DPS_BIT]; // R4
   assign dp_lo = ptr_slot(dp_sel, 1'b0);
   assign dp_hi = ptr_slot(dp_sel, 1'b1);
   assign dp_val = {st_q.special_function_register[dp_hi], st_q.special_function_register[dp_lo]};
   assign dp_inc_val = dp_val + 16'h0001;

   // working bank and paged address
   // the low byte lives in RAM, so a bank switch moves it too
   assign bank = st_q.special_function_register[sfr_idx(`MDAS_PROG_STATUS_WORD)][`MDAS_BANK_HI:`MDAS_BANK_LO]; // R8
   assign ri_addr = {3'h0, bank, 2'h0, movx_ri_sel}; // R1
   assign pg_addr = {st_q.special_function_register[sfr_idx(`MDAS_MOVX_PAGE_HIGH)], st_q.ram[ri_addr]}; // R2

   // bit access byte and position
   assign bb = bit_byte(bit_addr);
   assign bpos = bit_addr[`MDAS_BITPOS_HI:0];

   // write strobe length and last address cycle of a write; the strobe
   // never drops below one cycle and a setup cycle comes before it
   assign cnt_nx = st_q.cnt + 4'h1;
   assign wlen = (st_q.strch == 3'h0) ? `MDAS_WR_STROBE_MIN : {1'b0, st_q.strch}; // R16
   assign wr_last = {1'b0, st_q.strch} + `MDAS_WR_ADDR_EXTRA; // R16

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // byte, bit, pointer and sequencer updates all land in one copy
   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.rd_valid = 1'b0;

      // one internal access a cycle: direct, then indirect, then bit;
      // a losing request is dropped, not queued
      if (dir_rd || dir_wr) begin
         st_d.rd_valid = dir_rd;
         if (!upper_half(dir_addr)) begin
            st_d.rd_data = st_q.ram[dir_addr]; // R10
            if (dir_wr) begin
               st_d.ram[dir_addr] = dir_wdata; // R10
            end
         end else if (sfr_impl(dir_addr)) begin
            st_d.rd_data = st_q.special_function_register[sfr_idx(dir_addr)]; // R7
            if (dir_wr) begin
               st_d.special_function_register[sfr_idx(dir_addr)] = dir_wdata;
            end
         end else begin
            st_d.rd_data = `MDAS_UNDEF_DATA; // R11
         end
      end else if (ind_rd || ind_wr) begin
         // whole byte range goes to RAM, so the upper half is its own space
         st_d.rd_valid = ind_rd;
         st_d.rd_data = st_q.ram[ind_addr]; // R6 R7 R10
         if (ind_wr) begin
            st_d.ram[ind_addr] = ind_wdata;
         end
      end else if (bit_rd || bit_wr) begin
         st_d.rd_valid = bit_rd;
         // a bit write rewrites its byte within the one cycle
         if (!upper_half(bb)) begin
            st_d.rd_bit = st_q.ram[bb][bpos]; // R9
            if (bit_wr) begin
               st_d.ram[bb][bpos] = bit_wval;
            end
         end else if (sfr_impl(bb)) begin
            st_d.rd_bit = st_q.special_function_register[sfr_idx(bb)][bpos]; // R12
            if (bit_wr) begin
               st_d.special_function_register[sfr_idx(bb)][bpos] = bit_wval;
            end
         end else begin
            st_d.rd_bit = `MDAS_UNDEF_BIT; // R11
         end
      end

      // pointer operations win over a byte write to the same pointer
      // the increment wraps at 16 bits; the other pointer stays put
      if (primary_data_ptr_load) begin
         st_d.special_function_register[dp_lo] = primary_data_ptr_load_val[7:0]; // R5 R18
         st_d.special_function_register[dp_hi] = primary_data_ptr_load_val[15:8];
      end else if (primary_data_ptr_inc) begin
         st_d.special_function_register[dp_lo] = dp_inc_val[7:0]; // R5 R18
         st_d.special_function_register[dp_hi] = dp_inc_val[15:8];
      end

      // external access sequencer; address and stretch latched at start,
      // so pointer or page changes mid-access do not disturb the bus
      // T is the taking cycle, n the latched stretch value:
      // read: address and strobe T+1..T+n+1, done in T+n+2
      // write: address T+1..T+n+2, strobe from T+2, done in T+n+3
      // a request while busy is dropped; wait for done
      case (st_q.xst)
         xs_idle: begin
            if (movx_req) begin
               st_d.strch = st_q.special_function_register[sfr_idx(`MDAS_MOVX_STRETCH_CTL)][`MDAS_STRETCH_HI:0]; // R15
               st_d.mem_addr = movx_paged ? pg_addr : dp_val; // R3 R14
               st_d.mem_addr_vld = 1'b1;
               st_d.busy = 1'b1;
               st_d.cnt = 4'h0;
               if (movx_wr) begin
                  st_d.xst = xs_write;
                  st_d.mem_wdata = movx_wdata;
                  // strobe stays off for the setup cycle
                  st_d.mem_wr = 1'b0;
               end else begin
                  st_d.xst = xs_read;
                  st_d.mem_rd = 1'b1;
               end
            end
         end
         xs_read: begin
            // strobe and address stand stretch plus one cycles
            if (st_q.cnt == {1'b0, st_q.strch}) begin
               st_d.mem_rd = 1'b0; // R16
               st_d.mem_addr_vld = 1'b0;
               st_d.busy = 1'b0;
               st_d.done = 1'b1;
               // memory data taken at the end of the last strobe cycle
               st_d.movx_rdata = mem_rdata;
               st_d.xst = xs_idle;
            end else begin
               st_d.cnt = cnt_nx;
            end
         end
         xs_write: begin
            // address stands stretch plus two, strobe sits inside it
            if (st_q.cnt == wr_last) begin
               st_d.mem_wr = 1'b0;
               st_d.mem_addr_vld = 1'b0; // R16
               st_d.busy = 1'b0;
               st_d.done = 1'b1;
               st_d.xst = xs_idle;
            end else begin
               st_d.cnt = cnt_nx;
               st_d.mem_wr = (cnt_nx <= wlen); // R16
            end
         end
         default: begin
            st_d.xst = xs_idle;
            st_d.mem_rd = 1'b0;
            st_d.mem_wr = 1'b0;
            st_d.mem_addr_vld = 1'b0;
            st_d.busy = 1'b0;
         end
      endcase

      // reset last, so it overrides every update above
      if (sys_rst) begin
         st_d = reset_state(); // R13 R17
      end
   end

   // ----------------------------------------------------------------
   // register
   // ----------------------------------------------------------------
   // RAM rides in the state word too, so one register covers all
   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   // ----------------------------------------------------------------
   // outputs, each a field of the state
   // ----------------------------------------------------------------
   // no logic after the flops, so pins settle right after the edge
   assign rd_valid_q = st_q.rd_valid;
   assign rd_data_q = st_q.rd_data;
   assign rd_bit_q = st_q.rd_bit;
   assign movx_busy_q = st_q.busy;
   assign movx_done_q = st_q.done;
   assign movx_rdata_q = st_q.movx_rdata;
   assign mem_addr_q = st_q.mem_addr;
   assign mem_addr_vld_q = st_q.mem_addr_vld;
   assign mem_rd_q = st_q.mem_rd;
   assign mem_wr_q = st_q.mem_wr;
   assign mem_wdata_q = st_q.mem_wdata;

endmodule

// file: tb/mdas_xmem.sv
// external data memory model behind the access sequencer
`timescale 1ns/10ps

module mdas_xmem #(
   parameter int lat = 0
) (
   // clock
   input wire logic clk,
   // memory side
   input wire logic [15:0] mem_addr_q,
   input wire logic mem_rd_q,
   input wire logic mem_wr_q,
   input wire logic [7:0] mem_wdata_q,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   int cnt;
   // pattern depends on both address bytes, so a wrong page shows
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'(i >> 8);
      end
   end
   // store on the write strobe, count read strobe cycles
   always @(posedge clk) begin
      if (mem_wr_q) begin
         mem[mem_addr_q] <= mem_wdata_q;
      end
      cnt <= mem_rd_q ? cnt + 1 : 0;
   end
   // slow part: data good only after lat strobe cycles, inverse otherwise
   assign mem_rdata = (mem_rd_q && cnt >= lat) ? mem[mem_addr_q] : ~mem[mem_addr_q];
endmodule

// file: tb/mdas_props.sv
// assertions on the ports of the data addressing block
`timescale 1ns/10ps

module mdas_props (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // internal access
   input wire logic dir_rd,
   input wire logic dir_wr,
   input wire logic [7:0] dir_addr,
   input wire logic [7:0] dir_wdata,
   input wire logic ind_rd,
   input wire logic ind_wr,
   input wire logic bit_rd,
   input wire logic rd_valid_q,
   // external access
   input wire logic movx_req,
   input wire logic movx_wr,
   input wire logic movx_busy_q,
   input wire logic movx_done_q,
   input wire logic [15:0] mem_addr_q,
   input wire logic mem_addr_vld_q,
   input wire logic mem_rd_q,
   input wire logic mem_wr_q
);
   logic rst_q, wk_q;
   logic [2:0] n_q, nl_q;
   logic [3:0] rdc_q, wrc_q, vlc_q;
   // shadow the stretch value and measure strobe runs
   always_ff @(posedge clk) begin
      rst_q <= sys_rst;
      n_q <= sys_rst ? 3'h1 : (dir_wr && dir_addr == 8'h8e) ? dir_wdata[2:0] : n_q;
      if (movx_req && !movx_busy_q) begin
         nl_q <= n_q;
         wk_q <= movx_wr;
      end
      rdc_q <= mem_rd_q ? rdc_q + 4'h1 : 4'h0;
      wrc_q <= mem_wr_q ? wrc_q + 4'h1 : 4'h0;
      vlc_q <= mem_addr_vld_q ? vlc_q + 4'h1 : 4'h0;
   end
   default clocking @(posedge clk); endclocking
   // the cycle after reset still sees reset-time values
   default disable iff (sys_rst || rst_q);
   property p_rd_len; $fell(mem_rd_q) |-> rdc_q == nl_q + 4'h1; endproperty
   property p_wr_len; $fell(mem_wr_q) |-> wrc_q == (nl_q == 3'h0 ? 4'h1 : {1'b0, nl_q});
   endproperty
   property p_vld_len; $fell(mem_addr_vld_q) |-> vlc_q == nl_q + (wk_q ? 4'h2 : 4'h1);
   endproperty
   property p_done; $fell(mem_addr_vld_q) |-> movx_done_q && !movx_busy_q; endproperty
   property p_take;
      movx_req && !movx_busy_q |=> movx_busy_q && mem_addr_vld_q && mem_rd_q == !$past(movx_wr);
   endproperty
   property p_done_pulse; movx_done_q |=> !movx_done_q; endproperty
   property p_rd_valid;
      rd_valid_q == $past(dir_rd || (!dir_wr && (ind_rd || (!ind_wr && bit_rd))));
   endproperty
   property p_strobe; mem_rd_q || mem_wr_q |-> mem_addr_vld_q && !(mem_rd_q && mem_wr_q);
   endproperty
   property p_addr_hold; mem_addr_vld_q && $past(mem_addr_vld_q) |-> $stable(mem_addr_q);
   endproperty
   property p_rst_out;
      disable iff (sys_rst) rst_q |-> !movx_busy_q && !mem_rd_q && !mem_wr_q && !rd_valid_q;
   endproperty
   a_rd_len: assert property (p_rd_len) else $error("read strobe width");
   a_wr_len: assert property (p_wr_len) else $error("write strobe width");
   a_vld_len: assert property (p_vld_len) else $error("address width");
   a_done: assert property (p_done) else $error("done not after address");
   a_take: assert property (p_take) else $error("access not started");
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   a_rd_valid: assert property (p_rd_valid) else $error("read answer timing");
   a_strobe: assert property (p_strobe) else $error("strobe outside address");
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
   c_read: cover property ($fell(mem_rd_q));
   c_write: cover property ($fell(mem_wr_q));
   c_bit: cover property (bit_rd ##1 rd_valid_q);
endmodule

bind mdas_top mdas_props i_props (.*);

// file: tb/testbench.sv
// self-checking bench for the data addressing block
`timescale 1ns/10ps

module testbench;
   logic clk, sys_rst, bit_wval, primary_data_ptr_load, primary_data_ptr_inc;
   logic dir_rd, dir_wr, ind_rd, ind_wr, bit_rd, bit_wr;
   logic [7:0] dir_addr, dir_wdata, ind_addr, ind_wdata, bit_addr, movx_wdata;
   logic [15:0] primary_data_ptr_load_val;
   logic movx_req, movx_wr, movx_paged, movx_ri_sel;
   logic rd_valid_q, rd_bit_q, movx_busy_q, movx_done_q;
   logic [7:0] rd_data_q, movx_rdata_q, mem_wdata_q, mem_rdata;
   logic [15:0] mem_addr_q;
   logic mem_addr_vld_q, mem_rd_q, mem_wr_q;
   logic [5:0] rq;
   int fails, num_checks;
   logic [15:0] rt [12] = '{16'h80ff, 16'h8107, 16'h8e01, 16'h90ff, 16'hb0ff, 16'haad9,
      16'hba03, 16'hbb03, 16'h9200, 16'h8200, 16'ha000, 16'h9300};
   assign {dir_rd, dir_wr, ind_rd, ind_wr, bit_rd, bit_wr} = rq;

   mdas_top i_dut (.*);
   // slow memory: stretch zero reads are too early for it
   mdas_xmem #(.lat(1)) i_mem (.*);

   // ----------------------------------------------------------------
   // clock and tasks
   // ----------------------------------------------------------------
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task finish_test;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // k: 0 direct, 1 indirect, 2 bit
   task acc(input int k, input logic w, input logic [7:0] a, d);
      @(negedge clk);
      rq = 6'b100000 >> (2 * k + int'(w));
      {dir_addr, ind_addr, bit_addr, dir_wdata, ind_wdata, bit_wval} = {a, a, a, d, d, d[0]};
      @(negedge clk);
      rq = 6'h0;
   endtask
   task rd(input int k, input logic [7:0] a, e);
      acc(k, 1'b0, a, 8'h00);
      chk(16'(rd_valid_q), 16'h1);
      chk(k == 2 ? {15'h0, rd_bit_q} : {8'h0, rd_data_q}, {8'h0, e});
   endtask
   task dp(input logic ld, input logic [15:0] v);
      @(negedge clk);
      {primary_data_ptr_load, primary_data_ptr_inc, primary_data_ptr_load_val} = {ld, !ld, v};
      @(negedge clk);
      {primary_data_ptr_load, primary_data_ptr_inc} = 2'b00;
   endtask
   task mx(input logic w, pg, ri, input logic [7:0] wd, input int n,
           input logic [15:0] ea, input logic [7:0] ed);
      int rc, wc, i;
      @(negedge clk);
      {movx_req, movx_wr, movx_paged, movx_ri_sel, movx_wdata} = {1'b1, w, pg, ri, wd};
      @(negedge clk);
      movx_req = 0;
      rc = 0;
      wc = 0;
      i = 0;
      while (movx_done_q !== 1'b1 && i < 30) begin
         rc += int'(mem_rd_q);
         wc += int'(mem_wr_q);
         i++;
         @(negedge clk);
      end
      chk(16'(movx_done_q), 16'h1);
      chk(mem_addr_q, ea);
      chk(16'(rc), 16'(w ? 0 : n + 1));
      chk(16'(wc), 16'(w ? (n == 0 ? 1 : n) : 0));
      if (!w) chk({8'h0, movx_rdata_q}, {8'h0, ed});
   endtask

   // ----------------------------------------------------------------
   // watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      #100us;
      fails++;
      finish_test();
   end
   initial begin
      {sys_rst, rq, bit_wval, primary_data_ptr_load, primary_data_ptr_inc, primary_data_ptr_load_val} = {1'b1, 25'h0};
      {dir_addr, dir_wdata, ind_addr, ind_wdata, bit_addr} = 40'h0;
      {movx_req, movx_wr, movx_paged, movx_ri_sel, movx_wdata} = 12'h0;
      repeat (16) @(negedge clk);
      sys_rst = 0;
      foreach (rt[i]) rd(0, rt[i][15:8], rt[i][7:0]);
      acc(0, 1, 8'h93, 8'h5a);
      rd(0, 8'h93, 8'h00);
      acc(0, 1, 8'h45, 8'h5a);
      rd(1, 8'h45, 8'h5a);
      acc(1, 1, 8'h90, 8'h3c);
      rd(0, 8'h90, 8'hff);
      rd(1, 8'h90, 8'h3c);
      acc(2, 1, 8'h0b, 8'h01);
      rd(0, 8'h21, 8'h08);
      rd(2, 8'h0b, 8'h01);
      acc(2, 1, 8'h91, 8'h00);
      rd(0, 8'h90, 8'hfd);
      acc(2, 1, 8'h8a, 8'h01);
      rd(0, 8'h88, 8'h04);
      rd(0, 8'h8a, 8'h00);
      // paged form through bank two, then bank one
      acc(0, 1, 8'hd0, 8'h10);
      acc(0, 1, 8'h10, 8'h33);
      acc(0, 1, 8'h11, 8'h44);
      acc(0, 1, 8'hbf, 8'h12);
      mx(0, 1, 1, 0, 1, 16'h1244, 8'h56);
      acc(0, 1, 8'hd0, 8'h08);
      acc(1, 1, 8'h08, 8'h77);
      mx(0, 1, 0, 0, 1, 16'h1277, 8'h65);
      // both pointers, switched select
      dp(1, 16'h1234);
      acc(0, 1, 8'h92, 8'h01);
      dp(1, 16'habcd);
      dp(0, 16'h0);
      rd(0, 8'h82, 8'h34);
      rd(0, 8'h83, 8'h12);
      rd(0, 8'h84, 8'hce);
      rd(0, 8'h85, 8'hab);
      mx(0, 0, 0, 0, 1, 16'habce, 8'h65);
      acc(0, 1, 8'h92, 8'h00);
      // every stretch value, upper control bits set, forms mixed
      for (int n = 0; n < 8; n++) begin
         acc(0, 1, 8'h8e, {5'h15, 3'(n)});
         mx(1, 0, 0, 8'(n + 64), n, 16'h1234, 8'h0);
         mx(0, 1, 0, 0, n, 16'h1277, n == 0 ? 8'h9a : 8'h65);
         mx(0, 0, 0, 0, n, 16'h1234, n == 0 ? ~8'(n + 64) : 8'(n + 64));
      end
      // paged write read back, bit hole, then a reset in mid-run
      mx(1, 1, 0, 8'h5c, 7, 16'h1277, 8'h00);
      mx(0, 1, 0, 0, 7, 16'h1277, 8'h5c);
      acc(2, 1, 8'hc9, 8'h01);
      rd(2, 8'hc9, 8'h00);
      sys_rst = 1;
      repeat (2) @(negedge clk);
      sys_rst = 0;
      rd(0, 8'h8e, 8'h01);
      rd(1, 8'h45, 8'h00);
      finish_test();
   end
endmodule
